// ---- hdl/cfg_addr_pkg.sv ----
// constants for the host configuration-address block
package cfg_addr_pkg;

  // config_target_address field layout
  localparam int ENABLE_BIT = 31;
  localparam int BUS_HI = 23;
  localparam int BUS_LO = 16;
  localparam int DEV_HI = 15;
  localparam int DEV_LO = 11;
  localparam int FN_HI = 10;
  localparam int FN_LO = 8;
  localparam int REG_HI = 7;
  localparam int REG_LO = 2;
  localparam int BUS_W = 8;
  localparam int DEV_W = 5;
  localparam int FN_W = 3;
  localparam int REG_W = 6;
  localparam int IDSEL_W = 16;
  localparam int IDSEL_BASE = 16;

  // enable flag is hardwired, reserved bits read zero
  localparam logic ENABLE_VALUE = 1'b1;
  localparam logic [6:0] RSVD_HI_VALUE = 7'h00;
  localparam logic [1:0] RSVD_LO_VALUE = 2'h0;
  localparam logic [7:0] TYPE1_PAD = 8'h00;
  localparam logic [4:0] TYPE0_PAD = 5'h00;

  // special cycle trigger value
  localparam logic [31:0] SPECIAL_TRIGGER = 32'h8000_ff00;

  // low address bits telling the target the address type
  localparam logic [1:0] ADDR_TYPE0 = 2'h0;
  localparam logic [1:0] ADDR_TYPE1 = 2'h1;

  // bus commands driven on the command/byte-enable lines
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_CFG_READ = 4'ha;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
  localparam logic [3:0] ALL_BYTES = 4'h0;

  // data returned when no target claims a read
  localparam logic [31:0] ABORT_DATA = 32'hffff_ffff;

  // link-side timing, in link clocks
  localparam logic [2:0] DEVSEL_TIMEOUT = 3'h5;
  localparam logic [2:0] SPECIAL_LENGTH = 3'h4;

  // local peripheral bus register select
  localparam logic SEL_ADDR_REG = 1'b0;
  localparam logic SEL_DATA_PORT = 1'b1;

  typedef enum logic [2:0] {
    C_IDLE = 3'b001,
    C_WAIT = 3'b010,
    C_DONE = 3'b100
  } core_state_t;

  typedef enum logic [3:0] {
    L_IDLE = 4'b0001,
    L_ADDR = 4'b0010,
    L_DATA = 4'b0100,
    L_TURN = 4'b1000
  } link_state_t;

endpackage

// ---- hdl/bit_sync.sv ----
// two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // no reset, so it can also carry a reset level across
  always_ff @(posedge clk) begin
    meta <= async_in;
    sync_out <= meta;
  end

endmodule

// ---- hdl/pci_host_config_address.sv ----
// host bridge configuration-address register and configuration cycle launcher
//
// Overview of operation
// RULE_01: reading or writing the data port launches a configuration cycle from stored fields
// RULE_02: bridge follows configuration mechanism 1; address register is its address port
// RULE_03: address register 8000FF00 plus data port write issues a special cycle
// RULE_04: bit 31 enable reads one always; other fields survive every reset
// RULE_05: bits 30..24 and 1..0 read zero; software writes zero there
// RULE_06: bits 23..16 hold target bus number; zero is the bridge's own bus
// RULE_07: bits 15..11 hold the 5-bit target device number
// RULE_08: configuration cycle drives exactly AD[16 + device] high as IDSEL
// RULE_09: device number 10h or above leaves AD[31:16] all low
// RULE_10: bits 10..8 hold the 3-bit function number
// RULE_11: bits 7..2 hold the longword register index placed on address lines
// RULE_12: software loads the address register before each data port access
// RULE_13: address register reachable only from the local peripheral bus
// RULE_14: configuration cycles launch only while the bridge is PCI host
// RULE_15: bus zero gives a type 0 address, other buses a type 1 address
`timescale 1ns/1ps
module pci_host_config_address
  import cfg_addr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic host_mode,
  input wire logic lpb_req,
  input wire logic lpb_sel,
  input wire logic lpb_we,
  input wire logic [31:0] lpb_wdata,
  output logic lpb_ack,
  output logic [31:0] lpb_rdata,
  output logic lpb_abort,
  output logic cfg_busy,
  input wire logic pci_clk,
  input wire logic [31:0] ad_i,
  output logic [31:0] ad_o,
  output logic ad_oe_n,
  output logic [3:0] cbe_o,
  output logic cbe_oe_n,
  output logic frame_n_o,
  output logic frame_oe_n,
  output logic irdy_n_o,
  output logic irdy_oe_n,
  input wire logic trdy_n_i,
  input wire logic devsel_n_i
);

  // ---------------- core domain ----------------
  logic [BUS_W-1:0] bus_number;
  logic [DEV_W-1:0] dev_number;
  logic [FN_W-1:0] fn_number;
  logic [REG_W-1:0] reg_index;
  logic [31:0] addr_readback;
  core_state_t core_state;
  core_state_t next_core_state;
  logic req_tgl;
  logic done_sync;
  logic done_seen;
  logic take;
  logic launch;
  logic [31:0] req_addr;
  logic [3:0] req_cmd;
  logic req_write;
  logic [31:0] req_wdata;
  logic [15:0] idsel_lines;
  logic [31:0] link_rdata;
  logic link_abort;

  // link domain
  logic link_rst_b;
  logic req_sync;
  logic req_seen;
  logic done_tgl;
  link_state_t link_state;
  link_state_t next_link_state;
  logic [2:0] wait_cnt;
  logic is_special;
  logic [31:0] addr_snap;
  logic [3:0] cmd_snap;
  logic write_snap;
  logic [31:0] wdata_snap;
  logic link_go;
  logic claimed;
  logic timed_out;

  // RULE_04 enable hardwired; RULE_05 reserved bits zero
  assign addr_readback = {ENABLE_VALUE, RSVD_HI_VALUE, bus_number, dev_number, fn_number, reg_index,
                          RSVD_LO_VALUE};

  assign take = (core_state == C_IDLE) && lpb_req;
  // RULE_14 host only; RULE_01 data port access launches
  assign launch = take && (lpb_sel == SEL_DATA_PORT) && host_mode;
  assign done_seen = (done_sync == req_tgl);

  always_comb begin
    next_core_state = core_state;
    unique case (core_state)
      C_IDLE: begin
        if (launch) begin
          next_core_state = C_WAIT;
        end else if (take) begin
          next_core_state = C_DONE;
        end
      end
      C_WAIT: begin
        if (done_seen) begin
          next_core_state = C_DONE;
        end
      end
      C_DONE: begin
        next_core_state = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      core_state <= C_IDLE;
    end else begin
      core_state <= next_core_state;
    end
  end

  assign lpb_ack = (core_state == C_DONE);
  assign cfg_busy = (core_state == C_WAIT);

  // fields have no reset: their contents must survive power-on and soft resets
  // RULE_04 fields kept; RULE_13 only the local peripheral bus writes them
  always_ff @(posedge core_clk) begin
    if (take && lpb_we && (lpb_sel == SEL_ADDR_REG)) begin
      // RULE_06 bus number
      bus_number <= lpb_wdata[BUS_HI:BUS_LO];
      // RULE_07 device number
      dev_number <= lpb_wdata[DEV_HI:DEV_LO];
      // RULE_10 function number
      fn_number <= lpb_wdata[FN_HI:FN_LO];
      // RULE_11 register index
      reg_index <= lpb_wdata[REG_HI:REG_LO];
    end
  end

  // RULE_08 one-hot idsel from device number; RULE_09 none when device is 10h or more
  always_comb begin
    idsel_lines = '0;
    if (!dev_number[DEV_W-1]) begin
      idsel_lines[dev_number[DEV_W-2:0]] = 1'b1;
    end
  end

  // request word held steady while the toggle is in flight
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      req_addr <= '0;
      req_cmd <= CMD_CFG_READ;
      req_write <= 1'b0;
      req_wdata <= '0;
    end else if (launch) begin
      req_write <= lpb_we;
      req_wdata <= lpb_wdata;
      // RULE_03 special cycle on trigger value with a write
      if (lpb_we && (addr_readback == SPECIAL_TRIGGER)) begin
        req_cmd <= CMD_SPECIAL;
        req_addr <= '0;
      end else begin
        req_cmd <= lpb_we ? CMD_CFG_WRITE : CMD_CFG_READ;
        // RULE_15 type 0 on own bus, type 1 beyond
        if (bus_number == '0) begin
          req_addr <= {idsel_lines, TYPE0_PAD, fn_number, reg_index, ADDR_TYPE0};
        end else begin
          req_addr <= {TYPE1_PAD, bus_number, dev_number, fn_number, reg_index, ADDR_TYPE1};
        end
      end
    end
  end

  // RULE_02 mechanism 1: address port then data port
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      req_tgl <= 1'b0;
    end else if (launch) begin
      req_tgl <= ~req_tgl;
    end
  end

  // link result is stable once the done toggle has been seen
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      lpb_rdata <= '0;
      lpb_abort <= 1'b0;
    end else if ((core_state == C_WAIT) && done_seen) begin
      lpb_rdata <= req_write ? '0 : link_rdata;
      lpb_abort <= link_abort;
    end else if (take && !launch) begin
      lpb_rdata <= (lpb_sel == SEL_ADDR_REG) ? addr_readback : '0;
      lpb_abort <= 1'b0;
    end
  end

  bit_sync #(.W(1)) done_to_core (
    .clk(core_clk),
    .async_in(done_tgl),
    .sync_out(done_sync)
  );

  // ---------------- link domain ----------------
  bit_sync #(.W(2)) to_link (
    .clk(pci_clk),
    .async_in({rst_b, req_tgl}),
    .sync_out({link_rst_b, req_sync})
  );

  assign link_go = (req_sync != req_seen);
  assign claimed = !devsel_n_i && !trdy_n_i;
  assign timed_out = (wait_cnt == (is_special ? SPECIAL_LENGTH : DEVSEL_TIMEOUT));

  always_comb begin
    next_link_state = link_state;
    unique case (link_state)
      L_IDLE: begin
        if (link_go) begin
          next_link_state = L_ADDR;
        end
      end
      L_ADDR: begin
        next_link_state = L_DATA;
      end
      L_DATA: begin
        if ((claimed && !is_special) || timed_out) begin
          next_link_state = L_TURN;
        end
      end
      L_TURN: begin
        next_link_state = L_IDLE;
      end
    endcase
  end

  always_ff @(posedge pci_clk) begin
    if (!link_rst_b) begin
      link_state <= L_IDLE;
    end else begin
      link_state <= next_link_state;
    end
  end

  // core request fields are frozen while the toggle differs, so a plain capture is safe
  always_ff @(posedge pci_clk) begin
    if (!link_rst_b) begin
      req_seen <= 1'b0;
      addr_snap <= '0;
      cmd_snap <= CMD_CFG_READ;
      write_snap <= 1'b0;
      wdata_snap <= '0;
      is_special <= 1'b0;
    end else if ((link_state == L_IDLE) && link_go) begin
      req_seen <= req_sync;
      addr_snap <= req_addr;
      cmd_snap <= req_cmd;
      write_snap <= req_write;
      wdata_snap <= req_wdata;
      is_special <= (req_cmd == CMD_SPECIAL);
    end
  end

  always_ff @(posedge pci_clk) begin
    if (!link_rst_b) begin
      wait_cnt <= '0;
    end else if (link_state == L_DATA) begin
      wait_cnt <= wait_cnt + 3'h1;
    end else begin
      wait_cnt <= '0;
    end
  end

  // special cycles are never claimed; they always end by the length count
  always_ff @(posedge pci_clk) begin
    if (!link_rst_b) begin
      link_rdata <= '0;
      link_abort <= 1'b0;
      done_tgl <= 1'b0;
    end else if (link_state == L_DATA) begin
      if (claimed && !is_special) begin
        link_rdata <= ad_i;
        link_abort <= 1'b0;
        done_tgl <= ~done_tgl;
      end else if (timed_out) begin
        link_rdata <= ABORT_DATA;
        link_abort <= !is_special;
        done_tgl <= ~done_tgl;
      end
    end
  end

  // pin drive; irdy is driven high for one turn cycle before release, frame is driven high through the data phase and turn cycle
  always_ff @(posedge pci_clk) begin
    if (!link_rst_b) begin
      ad_o <= '0;
      ad_oe_n <= 1'b1;
      cbe_o <= ALL_BYTES;
      cbe_oe_n <= 1'b1;
      frame_n_o <= 1'b1;
      frame_oe_n <= 1'b1;
      irdy_n_o <= 1'b1;
      irdy_oe_n <= 1'b1;
    end else begin
      unique case (next_link_state)
        L_IDLE: begin
          ad_oe_n <= 1'b1;
          cbe_oe_n <= 1'b1;
          frame_oe_n <= 1'b1;
          irdy_oe_n <= 1'b1;
        end
        L_ADDR: begin
          // RULE_08 idsel rides the upper address lines; RULE_11 index below
          ad_o <= req_addr;
          ad_oe_n <= 1'b0;
          cbe_o <= req_cmd;
          cbe_oe_n <= 1'b0;
          frame_n_o <= 1'b0;
          frame_oe_n <= 1'b0;
        end
        L_DATA: begin
          ad_o <= wdata_snap;
          ad_oe_n <= !write_snap;
          cbe_o <= ALL_BYTES;
          frame_n_o <= 1'b1;
          irdy_n_o <= 1'b0;
          irdy_oe_n <= 1'b0;
        end
        L_TURN: begin
          ad_oe_n <= 1'b1;
          cbe_oe_n <= 1'b1;
          irdy_n_o <= 1'b1;
          frame_n_o <= 1'b1;
        end
      endcase
    end
  end

  // addr_snap and cmd_snap document what the link is running; kept for debug visibility
  logic unused_snap;
  assign unused_snap = ^{addr_snap, cmd_snap};

endmodule

// ---- testbench/pci_host_config_address_asserts.sv ----
// concurrent checks on the configuration-address block ports
`timescale 1ns/1ps
module pci_host_config_address_chk
  import cfg_addr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic host_mode,
  input wire logic lpb_req,
  input wire logic lpb_sel,
  input wire logic lpb_we,
  input wire logic [31:0] lpb_wdata,
  input wire logic lpb_ack,
  input wire logic [31:0] lpb_rdata,
  input wire logic cfg_busy,
  input wire logic pci_clk,
  input wire logic [31:0] ad_o,
  input wire logic [3:0] cbe_o,
  input wire logic frame_n_o,
  input wire logic frame_oe_n,
  input wire logic irdy_n_o,
  input wire logic ad_oe_n,
  input wire logic cbe_oe_n,
  input wire logic irdy_oe_n
);
  logic [31:0] areg;
  logic aph;
  // last value written, stable long before the link uses it
  always_ff @(posedge core_clk) begin
    if (lpb_req && !lpb_sel && lpb_we && lpb_ack) begin
      areg <= lpb_wdata;
    end
  end
  assign aph = !frame_n_o && !frame_oe_n;
  chk_addr_ack: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(lpb_req) && !lpb_sel |=> lpb_ack) else $error("address access not acked");
  chk_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    lpb_ack && !lpb_sel && !lpb_we |-> lpb_rdata[31] && lpb_rdata[30:24] == 7'h00 && lpb_rdata[1:0] == 2'h0)
    else $error("address readback bad");
  chk_nohost_ack: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(lpb_req) && lpb_sel && !host_mode |=> lpb_ack && lpb_rdata == 32'h0 && !cfg_busy)
    else $error("non-host access ran");
  chk_host_busy: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(lpb_req) && lpb_sel && host_mode |=> cfg_busy) else $error("no cycle launched");
  chk_busy_ack: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(cfg_busy) |-> lpb_ack) else $error("cycle end without ack");
  chk_ack_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
    lpb_ack |=> !lpb_ack) else $error("ack too long");
  chk_type0_addr: assert property (@(posedge pci_clk) disable iff (!rst_b)
    aph && $past(frame_n_o) && cbe_o[3:1] == 3'h5 && areg[23:16] == 8'h00 |->
    ad_o == {(areg[15] ? 16'h0000 : 16'h0001 << areg[14:11]), 5'h00, areg[10:2], 2'h0}) else $error("type 0 bad");
  chk_type1_addr: assert property (@(posedge pci_clk) disable iff (!rst_b)
    aph && $past(frame_n_o) && cbe_o[3:1] == 3'h5 && areg[23:16] != 8'h00 |->
    ad_o == {8'h00, areg[23:2], 2'h1}) else $error("type 1 bad");
  chk_special_addr: assert property (@(posedge pci_clk) disable iff (!rst_b)
    aph && $past(frame_n_o) && cbe_o == CMD_SPECIAL |-> ad_o == 32'h0 && areg == SPECIAL_TRIGGER)
    else $error("special cycle bad");
  chk_phase_len: assert property (@(posedge pci_clk) disable iff (!rst_b)
    aph && $past(frame_n_o) |=> frame_n_o && !irdy_n_o && !irdy_oe_n) else $error("address phase length");
  chk_addr_drive: assert property (@(posedge pci_clk) disable iff (!rst_b)
    aph |-> !ad_oe_n && !cbe_oe_n) else $error("address lines not driven");
endmodule

// ---- testbench/pci_target_model.sv ----
// behavioural targets on the attached bus
`timescale 1ns/1ps
module pci_target_model
  import cfg_addr_pkg::*;
(
  input wire logic pci_clk,
  input wire logic [31:0] ad_o,
  input wire logic ad_oe_n,
  input wire logic [3:0] cbe_o,
  input wire logic frame_n_o,
  input wire logic frame_oe_n,
  input wire logic [1:0] delay,
  input wire logic [31:0] rdata,
  output logic [31:0] ad_i,
  output logic trdy_n_i,
  output logic devsel_n_i,
  output logic [31:0] addr,
  output logic [3:0] cmd,
  output logic [31:0] wdata,
  output int cycles
);
  logic fr_q = 1'b1;
  logic drv = 1'b0;
  logic [2:0] cnt = 3'h0;
  logic [31:0] last = 32'h0;
  logic [31:0] t_ad = 32'h0;
  initial begin
    trdy_n_i = 1'b1;
    devsel_n_i = 1'b1;
    cycles = 0;
  end
  // undriven lines toggle so a stale value never passes
  assign ad_i = !ad_oe_n ? ad_o : drv ? t_ad : ~last;
  always @(posedge pci_clk) begin
    fr_q <= frame_n_o | frame_oe_n;
    last <= ad_i;
    if (!(frame_n_o | frame_oe_n) && fr_q) begin
      addr <= ad_o;
      cmd <= cbe_o;
      cycles <= cycles + 1;
      // claim on idsel or type 1
      if (cbe_o != CMD_SPECIAL && (ad_o[0] || ad_o[31:16] != 16'h0)) begin
        cnt <= 3'(delay) + 3'h1;
      end
    end else if (cnt > 3'h1) begin
      cnt <= cnt - 3'h1;
    end else if (cnt == 3'h1) begin
      devsel_n_i <= 1'b0;
      trdy_n_i <= 1'b0;
      drv <= cmd == CMD_CFG_READ;
      t_ad <= rdata;
      cnt <= 3'h0;
    end else if (!trdy_n_i) begin
      devsel_n_i <= 1'b1;
      trdy_n_i <= 1'b1;
      drv <= 1'b0;
      if (!ad_oe_n) begin
        wdata <= ad_o;
      end
    end
  end
endmodule

// ---- testbench/tb_top.sv ----
// register-level bench for the configuration-address block
`timescale 1ns/1ps
module tb_top;
  import cfg_addr_pkg::*;
  logic core_clk = 0, pci_clk = 0, rst_b = 0, host_mode = 1;
  logic lpb_req = 0, lpb_sel = 0, lpb_we = 0, abv;
  logic [31:0] lpb_wdata = 0, t_rdata = 0, lpb_rdata, ad_o, ad_i, m_addr, m_wdata, rdv;
  logic lpb_ack, lpb_abort, cfg_busy, ad_oe_n, cbe_oe_n, frame_n_o, frame_oe_n;
  logic irdy_n_o, irdy_oe_n, trdy_n_i, devsel_n_i;
  logic [3:0] cbe_o, m_cmd;
  logic [1:0] dly = 0;
  int mismatches = 0, compares = 0, m_cycles, n, d;
  int devs[5] = '{0, 7, 15, 16, 31};
  initial forever #4 core_clk = ~core_clk;
  initial begin
    #3;
    forever #7.5 pci_clk = ~pci_clk;
  end
  pci_host_config_address dut (.core_clk, .rst_b, .host_mode, .lpb_req, .lpb_sel, .lpb_we, .lpb_wdata,
    .lpb_ack, .lpb_rdata, .lpb_abort, .cfg_busy, .pci_clk, .ad_i, .ad_o, .ad_oe_n, .cbe_o, .cbe_oe_n,
    .frame_n_o, .frame_oe_n, .irdy_n_o, .irdy_oe_n, .trdy_n_i, .devsel_n_i);
  pci_target_model tgt (.pci_clk, .ad_o, .ad_oe_n, .cbe_o, .frame_n_o, .frame_oe_n, .delay(dly),
    .rdata(t_rdata), .ad_i, .trdy_n_i, .devsel_n_i, .addr(m_addr), .cmd(m_cmd), .wdata(m_wdata),
    .cycles(m_cycles));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic acc(input logic sel, input logic we, input logic [31:0] wd);
    int i;
    @(negedge core_clk);
    lpb_sel = sel;
    lpb_we = we;
    lpb_wdata = wd;
    lpb_req = 1;
    for (i = 0; i < 300 && lpb_ack !== 1'b1; i++) @(negedge core_clk);
    if (i == 300) begin
      mismatches++;
      end_of_test();
    end
    rdv = lpb_rdata;
    abv = lpb_abort;
    @(negedge core_clk);
    lpb_req = 0;
  endtask
  task automatic rst_pulse();
    @(negedge core_clk);
    rst_b = 0;
    repeat (8) @(negedge core_clk);
    rst_b = 1;
    repeat (8) @(negedge core_clk);
  endtask
  initial begin
    // reset held from time zero for five core clocks
    repeat (5) @(negedge core_clk);
    rst_b = 1;
    repeat (8) @(negedge core_clk);
    // software keeps reserved bits zero; bit 31 must still read back one
    acc(0, 1, 32'h0005_2a9c);
    acc(0, 0, 0);
    chk(rdv, 32'h8005_2a9c);
    t_rdata = 32'hcafe_0001;
    dly = 2;
    acc(1, 0, 0);
    chk(rdv, 32'hcafe_0001);
    chk(m_addr, 32'h0005_2a9d);
    chk(32'(m_cmd), 32'(CMD_CFG_READ));
    dly = 0;
    foreach (devs[k]) begin
      d = devs[k];
      acc(0, 1, 32'h8000_0340 | 32'(d << 11));
      acc(1, 1, 32'h5a00_0000 + d);
      chk(m_addr, (d < 16 ? 32'h1 << (16 + d) : 32'h0) | 32'h340);
      chk(32'(m_cmd), 32'(CMD_CFG_WRITE));
      chk(32'(abv), 32'(d >= 16));
      if (d < 16) chk(m_wdata, 32'h5a00_0000 + d);
    end
    acc(0, 1, SPECIAL_TRIGGER);
    acc(1, 0, 0);
    chk(rdv, ABORT_DATA);
    chk(m_addr, 32'h0000_0700);
    n = m_cycles;
    acc(0, 1, SPECIAL_TRIGGER);
    acc(1, 1, 32'h0000_1234);
    chk(32'(m_cmd), 32'(CMD_SPECIAL));
    chk(32'(abv), 32'h0);
    chk(m_cycles - n, 1);
    host_mode = 0;
    n = m_cycles;
    acc(1, 0, 0);
    chk(rdv, 32'h0);
    chk(m_cycles, n);
    host_mode = 1;
    acc(0, 1, 32'h80ff_f8fc);
    acc(1, 1, 32'h1);
    chk(m_addr, 32'h00ff_f8fd);
    rst_pulse();
    acc(0, 0, 0);
    chk(rdv, 32'h80ff_f8fc);
    end_of_test();
  end
endmodule
bind pci_host_config_address pci_host_config_address_chk chk_i (.core_clk, .rst_b, .host_mode, .lpb_req,
  .lpb_sel, .lpb_we, .lpb_wdata, .lpb_ack, .lpb_rdata, .cfg_busy, .pci_clk, .ad_o, .cbe_o, .frame_n_o,
  .frame_oe_n, .irdy_n_o, .ad_oe_n, .cbe_oe_n, .irdy_oe_n);
